/* logic/phy_port_status_interrupt.v */
// Port status reporting and interrupt logic behind a classic Wishbone slave.
// What this block does
// - Bit 14 reads 1 at 100 Mb/s.
// - Bits 13/12 show live transmit/receive activity.
// - Bits 11/10/9 show collision, link, full duplex.
// - Bit 8 shows auto-negotiation mode.
// - Bit 7 shows negotiation complete while negotiation is enabled.
// - Bit 5 shows reversed receive polarity.
// - Bit 4 mirrors partner pause capability.
// - Bit 3 shows an error such as remote fault.
// - Enable bits 7..4 unmask events, reset zero.
// - Enable bit 1 gates all interrupts, resets zero.
// - Enable bit 0 forces interrupt for test.
// - Status bit 7 flags negotiation done, read-clears.
// - Status bit 6 latches speed change until read.
// - Status bit 5 latches duplex change until read.
// - Status bit 4 latches link change until read.
// - Status bit 2 shows interrupt pending.
// - Reading status returns events then clears them.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`include "phy_port_status_regs.vh"

module phy_port_status_interrupt (
    input  wire        i_clk,
    input  wire        i_sys_rst,
    // Wishbone classic slave.
    input  wire        i_wb_cyc,
    input  wire        i_wb_stb,
    input  wire        i_wb_we,
    input  wire [9:0]  i_wb_adr,
    input  wire [3:0]  i_wb_sel,
    input  wire [31:0] i_wb_dat,
    output reg  [31:0] o_wb_dat,
    output reg         o_wb_ack,
    output reg         o_wb_err,
    // Port state levels from the transceiver core, asynchronous to i_clk.
    input  wire        i_speed_100,
    input  wire        i_tx_active,
    input  wire        i_rx_active,
    input  wire        i_collision,
    input  wire        i_link_up,
    input  wire        i_full_duplex,
    input  wire        i_neg_enabled,
    input  wire        i_neg_complete,
    input  wire        i_polarity_rev,
    input  wire        i_partner_pause,
    input  wire        i_port_error,
    // Interrupt pin, active low.
    output reg         o_irq_pending_out_n
);

    // ============================================================
    // Input synchronisation
    // ============================================================
    wire [10:0] st_s;

    pin_sync2 #(
        .WIDTH (11)
    ) u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_speed_100, i_tx_active, i_rx_active, i_collision, i_link_up,
                     i_full_duplex, i_neg_enabled, i_neg_complete, i_polarity_rev,
                     i_partner_pause, i_port_error}),
        .o_sync    (st_s)
    );

    // Named copies of the synchronised bundle, in port order.
    // A pin change reaches the status register three cycles later; a pulse
    // shorter than one clock period may be missed, which is fine for levels.
    wire speed_s  = st_s[10];
    wire txact_s  = st_s[9];
    wire rxact_s  = st_s[8];
    wire coll_s   = st_s[7];
    wire link_s   = st_s[6];
    wire dup_s    = st_s[5];
    wire negen_s  = st_s[4];
    wire negdn_s  = st_s[3];
    wire polrev_s = st_s[2];
    wire pause_s  = st_s[1];
    wire error_s  = st_s[0];

    // ============================================================
    // Live quick status
    // ============================================================
    reg [15:0] quick_q;
    reg [15:0] quick_d;

    always @* begin
        quick_d                 = `QS_RESET;
        quick_d[`QS_SPEED100]   = speed_s;
        quick_d[`QS_TX_ACT]     = txact_s;
        quick_d[`QS_RX_ACT]     = rxact_s;
        quick_d[`QS_COLLISION]  = coll_s;
        quick_d[`QS_LINK]       = link_s;
        quick_d[`QS_FULL_DUPLEX]= dup_s;
        quick_d[`QS_NEG_MODE]   = negen_s;
        quick_d[`QS_NEG_DONE]   = negen_s & negdn_s;
        quick_d[`QS_POL_REV]    = polrev_s;
        quick_d[`QS_PAUSE]      = pause_s;
        quick_d[`QS_ERROR]      = error_s;
    end

    // ============================================================
    // Helper functions
    // ============================================================
    // Exact match of the bus byte address against one register slot.
    function addr_hit;
        input [9:0] adr;
        input [9:0] slot;
        begin
            addr_hit = (adr == slot);
        end
    endfunction

    // Merges the two low byte lanes of a write into a 16-bit register.
    function [15:0] lane_merge;
        input [15:0] old_val;
        input [31:0] wdat;
        input [3:0]  sel;
        begin
            lane_merge = old_val;
            if (sel[0]) begin
                lane_merge[7:0] = wdat[7:0];
            end
            if (sel[1]) begin
                lane_merge[15:8] = wdat[15:8];
            end
        end
    endfunction

    // Any change of a level since the previous cycle.
    function toggled;
        input now_val;
        input prev_val;
        begin
            toggled = now_val ^ prev_val;
        end
    endfunction

    // A low-to-high step of a level since the previous cycle.
    function rose;
        input now_val;
        input prev_val;
        begin
            rose = now_val & ~prev_val;
        end
    endfunction

    // ============================================================
    // Bus answer state
    // ============================================================
    // One answer per request: the slave sits in the answer state for the
    // single cycle in which ack or err is high, so a strobe that is still
    // held there is not taken a second time.
    localparam [1:0] BUS_IDLE   = 2'b01;
    localparam [1:0] BUS_ANSWER = 2'b10;

    reg [1:0] bus_state_q;
    reg [1:0] bus_state_d;

    always @* begin
        bus_state_d = bus_state_q;
        case (bus_state_q)
            BUS_IDLE: begin
                if (i_wb_cyc & i_wb_stb) begin
                    bus_state_d = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                bus_state_d = BUS_IDLE;
            end
            default: begin
                bus_state_d = BUS_IDLE;
            end
        endcase
    end

    // ============================================================
    // Bus decode
    // ============================================================
    wire req     = i_wb_cyc & i_wb_stb & (bus_state_q == BUS_IDLE);
    wire hit_qs  = addr_hit(i_wb_adr, `ADR_QUICK_STATUS);
    wire hit_ie  = addr_hit(i_wb_adr, `ADR_IRQ_ENABLE);
    wire hit_is  = addr_hit(i_wb_adr, `ADR_IRQ_STATUS);
    wire mapped  = hit_qs | hit_ie | hit_is;
    wire rd_is   = req & ~i_wb_we & hit_is;

    // ============================================================
    // Enable register
    // ============================================================
    reg [15:0] ie_q;
    reg [15:0] ie_d;

    // Reserved enable bits are held at zero, so they always read back 0.
    // The write lands on the edge that takes the request.
    always @* begin
        ie_d = ie_q;
        if (req & i_wb_we & hit_ie) begin
            ie_d = lane_merge(ie_q, i_wb_dat, i_wb_sel) & `IE_WRITE_MASK;
        end
    end

    // ============================================================
    // Event detection and read-clear latches
    // ============================================================
    reg        speed_prev_q;
    reg        link_prev_q;
    reg        dup_prev_q;
    reg        negdn_prev_q;
    reg  [3:0] ev_q;
    reg  [3:0] ev_d;
    wire [3:0] ev_new;

    // Order: negotiation done, rate, duplex, link.
    // Negotiation done counts only while negotiation is enabled, matching the
    // live completion bit of the quick status word.
    assign ev_new = {rose(negen_s & negdn_s, negdn_prev_q),
                     toggled(speed_s, speed_prev_q),
                     toggled(dup_s, dup_prev_q),
                     toggled(link_s, link_prev_q)};

    always @* begin
        ev_d = ev_q;
        if (rd_is) begin
            ev_d = `EVENT_RESET;
        end
        // An event in the read cycle survives into the next interval.
        ev_d = ev_d | ev_new;
    end

    // ============================================================
    // Interrupt decision
    // ============================================================
    // The pending bit and the pin share one term, so software never sees
    // the pin low with pending clear unless the test force is on.
    wire [3:0] ev_mask  = {ie_q[`IE_NEG_DONE], ie_q[`IE_RATE],
                           ie_q[`IE_DUP], ie_q[`IE_LINK]};
    wire [3:0] unmasked = ev_q & ev_mask;
    wire       pending  = |unmasked;
    wire       irq_on   = ie_q[`IE_PORT] & (pending | ie_q[`IE_TEST]);

    // ============================================================
    // Read data
    // ============================================================
    // Unmapped addresses read as zero and are answered with err.
    reg  [15:0] rdata;
    wire [2:0]  rd_sel = {hit_qs, hit_ie, hit_is};

    always @* begin
        rdata = 16'h0000;
        case (rd_sel)
            3'b100: begin
                rdata = quick_q;
            end
            3'b010: begin
                rdata = ie_q;
            end
            3'b001: begin
                rdata[`IS_NEG_DONE] = ev_q[3];
                rdata[`IS_RATE]     = ev_q[2];
                rdata[`IS_DUP]      = ev_q[1];
                rdata[`IS_LINK]     = ev_q[0];
                rdata[`IS_PENDING]  = pending;
            end
            default: begin
                rdata = 16'h0000;
            end
        endcase
    end

    // ============================================================
    // Live status register
    // ============================================================
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            quick_q <= `QS_RESET;
        end else begin
            quick_q <= quick_d;
        end
    end

    // ============================================================
    // Enable register
    // ============================================================
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            ie_q <= `IE_RESET;
        end else begin
            ie_q <= ie_d;
        end
    end

    // ============================================================
    // Event latches and level history
    // ============================================================
    // The history flops reset to the same zero as the synchroniser, so a
    // level that is already high at release is reported once as a change.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            ev_q         <= `EVENT_RESET;
            speed_prev_q <= 1'b0;
            link_prev_q  <= 1'b0;
            dup_prev_q   <= 1'b0;
            negdn_prev_q <= 1'b0;
        end else begin
            ev_q         <= ev_d;
            speed_prev_q <= speed_s;
            link_prev_q  <= link_s;
            dup_prev_q   <= dup_s;
            negdn_prev_q <= negen_s & negdn_s;
        end
    end

    // ============================================================
    // Bus answer registers
    // ============================================================
    // Write cycles return zero data, so stale status never shows on the bus.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            bus_state_q <= BUS_IDLE;
            o_wb_ack    <= 1'b0;
            o_wb_err    <= 1'b0;
            o_wb_dat    <= 32'h0000_0000;
        end else begin
            bus_state_q <= bus_state_d;
            o_wb_ack    <= req & mapped;
            o_wb_err    <= req & ~mapped;
            o_wb_dat    <= (req & ~i_wb_we) ? {16'h0000, rdata} : 32'h0000_0000;
        end
    end

    // ============================================================
    // Interrupt pin
    // ============================================================
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_irq_pending_out_n <= 1'b1;
        end else begin
            o_irq_pending_out_n <= ~irq_on;
        end
    end

endmodule // phy_port_status_interrupt

/* logic/phy_port_status_regs.vh */
// Register map, field positions and reset values of the port status and interrupt block.
`ifndef PHY_PORT_STATUS_REGS_VH
`define PHY_PORT_STATUS_REGS_VH

// ============================================================
// Register indices and byte addresses
// ============================================================
`define IDX_QUICK_STATUS   8'h11
`define IDX_IRQ_ENABLE     8'h12
`define IDX_IRQ_STATUS     8'h13
`define ADR_W              10
`define ADR_QUICK_STATUS   10'h044
`define ADR_IRQ_ENABLE     10'h048
`define ADR_IRQ_STATUS     10'h04C

// ============================================================
// Quick status fields
// ============================================================
`define QS_SPEED100        14
`define QS_TX_ACT          13
`define QS_RX_ACT          12
`define QS_COLLISION       11
`define QS_LINK            10
`define QS_FULL_DUPLEX     9
`define QS_NEG_MODE        8
`define QS_NEG_DONE        7
`define QS_POL_REV         5
`define QS_PAUSE           4
`define QS_ERROR           3
`define QS_RESET           16'h0000

// ============================================================
// Interrupt enable and status fields
// ============================================================
`define IE_NEG_DONE        7
`define IE_RATE            6
`define IE_DUP             5
`define IE_LINK            4
`define IE_PORT            1
`define IE_TEST            0
`define IE_WRITE_MASK      16'h00F3
`define IE_RESET           16'h0000
`define IS_NEG_DONE        7
`define IS_RATE            6
`define IS_DUP             5
`define IS_LINK            4
`define IS_PENDING         2
`define EVENT_RESET        4'h0

`endif

/* logic/pin_sync2.v */
// Two-stage synchroniser for a bundle of asynchronous status levels.
`timescale 1ns/1ps

module pin_sync2 #(
    parameter WIDTH = 8
) (
    input  wire             i_clk,
    input  wire             i_sys_rst,
    input  wire [WIDTH-1:0] i_async,
    output reg  [WIDTH-1:0] o_sync
);

    reg [WIDTH-1:0] meta_q;

    // The first stage is read only by the second stage.
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            meta_q <= {WIDTH{1'b0}};
            o_sync <= {WIDTH{1'b0}};
        end else begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end

endmodule // pin_sync2

/* verification/phy_port_status_interrupt_monitor.sv */
// Checker for bus answers, enable masks and the interrupt pin of the port block.
`timescale 1ns/1ps
`include "phy_port_status_regs.vh"
module port_irq_checker (
    input logic        i_clk,
    input logic        i_sys_rst,
    input logic        i_wb_cyc,
    input logic        i_wb_stb,
    input logic        i_wb_we,
    input logic [9:0]  i_wb_adr,
    input logic [31:0] i_wb_dat,
    input logic [31:0] o_wb_dat,
    input logic        o_wb_ack,
    input logic        o_wb_err,
    input logic        o_irq_pending_out_n
);
    // ==========
    // Enable shadow
    // ==========
    logic [15:0] ie_q;
    wire mapped = i_wb_adr inside {`ADR_QUICK_STATUS, `ADR_IRQ_ENABLE, `ADR_IRQ_STATUS};
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) ie_q <= `IE_RESET;
        else if (i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err && i_wb_we &&
                 i_wb_adr == `ADR_IRQ_ENABLE)
            ie_q <= i_wb_dat[15:0] & `IE_WRITE_MASK;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    sequence taken;
        i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err;
    endsequence
    sequence rd_ack(a);
        o_wb_ack && !i_wb_we && i_wb_adr == a;
    endsequence
    a_answer_kind: assert property (taken |=> o_wb_ack == $past(mapped) && o_wb_err != $past(mapped))
        else $error("bus answer kind wrong");
    a_ack_drop: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
    a_qs_reserved: assert property (rd_ack(`ADR_QUICK_STATUS) |->
        o_wb_dat[31:15] == 0 && !o_wb_dat[6] && o_wb_dat[2:0] == 0) else $error("qs reserved");
    a_ie_readback: assert property (rd_ack(`ADR_IRQ_ENABLE) |->
        o_wb_dat == {16'h0000, ie_q}) else $error("enable readback");
    a_pending_bit: assert property (rd_ack(`ADR_IRQ_STATUS) |->
        o_wb_dat[2] == |(o_wb_dat[7:4] & ie_q[7:4])) else $error("pending bit");
    a_is_reserved: assert property (rd_ack(`ADR_IRQ_STATUS) |->
        o_wb_dat[31:8] == 0 && !o_wb_dat[3] && o_wb_dat[1:0] == 0) else $error("is reserved");
    a_irq_needs_en: assert property (!o_irq_pending_out_n |-> $past(ie_q[1]))
        else $error("irq while disabled");
    a_test_force: assert property (ie_q[1] && ie_q[0] |=> !o_irq_pending_out_n)
        else $error("test force ignored");
endmodule // port_irq_checker
bind phy_port_status_interrupt port_irq_checker u_port_irq_checker (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
    .o_wb_err(o_wb_err), .o_irq_pending_out_n(o_irq_pending_out_n));

/* verification/wb_host_model.sv */
// Wishbone classic host model issuing single register reads and writes.
`timescale 1ns/1ps
module wb_host_model (
    input  logic        i_clk,
    input  logic        i_ack,
    input  logic        i_err,
    input  logic [31:0] i_dat,
    output logic        o_cyc,
    output logic        o_stb,
    output logic        o_we,
    output logic [9:0]  o_adr,
    output logic [3:0]  o_sel,
    output logic [31:0] o_dat
);
    initial {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} = '0;
    // Data lines invert on release, so a slave cannot live on stale write data.
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic late);
        int n;
        n = 0;
        @(posedge i_clk);
        {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} <= {2'b11, w, a, 4'h3, d};
        do begin
            @(posedge i_clk);
            n++;
        end while (!i_ack && !i_err && n < 20);
        r = i_dat;
        e = i_err;
        late = n >= 20;
        {o_cyc, o_stb, o_dat} <= {2'b00, ~d};
    endtask
endmodule // wb_host_model

/* verification/tb.sv */
// Self-checking bench for the port status and interrupt block.
`timescale 1ns/1ps
`include "phy_port_status_regs.vh"
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, x); end end
module tb;
    localparam logic [9:0] QS = `ADR_QUICK_STATUS, IE = `ADR_IRQ_ENABLE, IS = `ADR_IRQ_STATUS;
    logic        i_clk = 0, i_sys_rst = 1, cyc, stb, we, ack, err, irq_n, e, late;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wd, rdat, r, rnd;
    logic [10:0] st = '0;
    logic [10:0] flip [4] = '{11'h040, 11'h020, 11'h400, 11'h018};
    int          failures = 0, cmp_count = 0, b;
    phy_port_status_interrupt u_phy_port_status_interrupt (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
        .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
        .i_wb_dat(wd), .o_wb_dat(rdat), .o_wb_ack(ack), .o_wb_err(err),
        .i_speed_100(st[10]), .i_tx_active(st[9]), .i_rx_active(st[8]), .i_collision(st[7]),
        .i_link_up(st[6]), .i_full_duplex(st[5]), .i_neg_enabled(st[4]),
        .i_neg_complete(st[3]), .i_polarity_rev(st[2]), .i_partner_pause(st[1]),
        .i_port_error(st[0]), .o_irq_pending_out_n(irq_n));
    wb_host_model u_wb_host_model (.i_clk(i_clk), .i_ack(ack), .i_err(err), .i_dat(rdat),
        .o_cyc(cyc), .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wd));
    initial forever #2 i_clk = ~i_clk;
    function automatic logic [31:0] exp_qs(logic [10:0] s);
        return {17'h0, s[10:4], s[3] & s[4], 1'b0, s[2:0], 3'h0};
    endfunction
    task print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task xf(input logic w, input logic [9:0] a, input logic [31:0] d);
        u_wb_host_model.xfer(w, a, d, r, e, late);
        if (late) begin
            failures++;
            print_verdict;
        end
    endtask
    task rd(input logic [9:0] a, input logic [31:0] x);
        xf(1'b0, a, 32'h0);
        `CHK(r, x)
    endtask
    task wait_irq(input logic lvl);
        b = 0;
        while (irq_n !== lvl && b < 20) begin
            @(posedge i_clk);
            b++;
        end
        `CHK(irq_n, lvl)
        if (irq_n !== lvl) print_verdict;
    endtask
    initial begin
        void'($urandom(32'h58AB0C0C));
        repeat (4) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(IE, 32'h0);
        rd(IS, 32'h0);
        xf(1'b0, 10'h050, 32'h0);
        `CHK(e, 1'b1)
        $display("test reset_map done");
        for (int i = 0; i < 8; i++) begin
            st <= $urandom;
            rnd = $urandom;
            xf(1'b1, IE, rnd);
            rd(IE, {16'h0, rnd[15:0]} & `IE_WRITE_MASK);
            repeat (4) @(posedge i_clk);
            rd(QS, exp_qs(st));
        end
        $display("test quick_status done");
        xf(1'b1, IE, 32'h3);
        wait_irq(1'b0);
        xf(1'b1, IE, 32'h1);
        wait_irq(1'b1);
        st <= 11'h0;
        xf(1'b1, IE, 32'h2);
        repeat (4) @(posedge i_clk);
        xf(1'b0, IS, 32'h0);
        st <= 11'h040;
        repeat (6) @(posedge i_clk);
        `CHK(irq_n, 1'b1)
        rd(IS, 32'h10);
        xf(1'b1, IE, 32'hF2);
        for (int k = 0; k < 4; k++) begin
            st <= st ^ flip[k];
            wait_irq(1'b0);
            rd(IS, 32'h4 | (32'h10 << k));
            rd(IS, 32'h0);
            wait_irq(1'b1);
        end
        $display("test events done");
        print_verdict;
    end
endmodule // tb
